// ===== shared/eeprom_host_pkg.sv
// Constants, codes and timing for the multiplexed-bus memory host.
// Assumes a 25 MHz aclk; all cycle counts derive from CLK_PERIOD_NS.
package eeprom_host_pkg;

	localparam int CLK_PERIOD_NS = 40;

	// Pin timing in ns, as cycles rounded up
	localparam int ALE_WIDTH_NS = 80;
	localparam int ADDR_HOLD_NS = 20;
	localparam int FETCH_WIDTH_NS = 140;
	localparam int READ_WIDTH_NS = 150;
	localparam int STORE_WIDTH_NS = 120;
	localparam int DATA_HOLD_NS = 30;
	localparam logic [2:0] ALE_CYC = 3'((ALE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] ADDR_HOLD_CYC = 3'((ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] FETCH_CYC = 3'((FETCH_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] READ_CYC = 3'((READ_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] STORE_CYC = 3'((STORE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] DATA_HOLD_CYC = 3'((DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Byte-load window (longest time, rounded down) and program cycle time
	localparam int BYTE_LOAD_US = 100;
	localparam logic [11:0] BYTE_LOAD_CYC = 12'((BYTE_LOAD_US * 1000) / CLK_PERIOD_NS);
	localparam int PROG_CYCLE_MS = 5;
	localparam int PROG_CYCLE_CYC_DEFAULT = (PROG_CYCLE_MS * 1000000) / CLK_PERIOD_NS;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] CMD_OFS = 8'h04;
	localparam logic [7:0] ADDR_OFS = 8'h08;
	localparam logic [7:0] WDATA_OFS = 8'h0c;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] RDATA_OFS = 8'h14;

	// Field positions and reset values
	localparam int CTRL_GATE_HOLD_BIT = 0;
	localparam int CTRL_PAGE_MODE_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_WINDOW_BIT = 1;
	localparam int ST_POLL_TO_BIT = 2;
	localparam int ST_PAGE_ERR_BIT = 3;
	localparam int ST_REFUSED_BIT = 4;
	localparam int ST_TOGGLE_BIT = 5;
	localparam int TOGGLE_FLAG_BIT = 6;
	localparam int PAGE_LSB = 5;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		OP_FETCH = 3'h0,
		OP_READ = 3'h1,
		OP_WRITE = 3'h2,
		OP_GUARDED_WRITE = 3'h3,
		OP_UNGUARD = 3'h4,
		OP_LOCK_WRITE = 3'h5,
		OP_POLL = 3'h6
	} op_e;

	typedef enum logic [1:0] {
		CYC_FETCH = 2'h0,
		CYC_READ = 2'h1,
		CYC_STORE = 2'h2
	} cyc_kind_e;

	// Command sequence table: guard, then lock-open, then deactivation
	localparam int SEQ_TOTAL = 14;
	localparam logic [3:0] GUARD_BASE = 4'h0;
	localparam logic [3:0] GUARD_LAST = 4'h2;
	localparam logic [3:0] LOCK_BASE = 4'h3;
	localparam logic [3:0] LOCK_LAST = 4'h7;
	localparam logic [3:0] UNGUARD_BASE = 4'h8;
	localparam logic [3:0] UNGUARD_LAST = 4'hd;
	localparam logic [SEQ_TOTAL-1:0][12:0] SEQ_ADDR_DEFAULT = {
		13'h1555, 13'h0aaa, 13'h1555, 13'h1555, 13'h0aaa, 13'h1555,
		13'h1555, 13'h0aaa, 13'h1555, 13'h1555, 13'h0aaa,
		13'h1555, 13'h0aaa, 13'h1555};
	localparam logic [SEQ_TOTAL-1:0][7:0] SEQ_DATA_DEFAULT = {
		8'h20, 8'h55, 8'haa, 8'h80, 8'h55, 8'haa,
		8'h40, 8'h55, 8'haa, 8'h80, 8'h55,
		8'ha0, 8'h55, 8'haa};
	localparam logic [12:0] BLOCK_LOCK_ADDR_DEFAULT = 13'h1fff;

endpackage

// ===== core/bus_cycle_engine.sv
// One latched-address bus cycle on the multiplexed pins: fetch, read or store.
// Assumes start arrives only while idle; the bus input is synchronous to aclk.
`timescale 1ns/1ps
module bus_cycle_engine
	import eeprom_host_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic [1:0] kind,
	input wire logic [12:0] addr,
	input wire logic [7:0] wdata,
	output logic done,
	output logic store_fall,
	output logic [7:0] rdata,
	output logic ale,
	output logic ce_n,
	output logic fetch_strobe_n,
	output logic rd_n,
	output logic wr_n,
	output logic [4:0] addr_hi,
	output logic [7:0] bus_o,
	output logic bus_oe,
	input wire logic [7:0] bus_i
);

	typedef enum logic [4:0] {
		E_IDLE = 5'b00001,
		E_ADDR = 5'b00010,
		E_HOLD = 5'b00100,
		E_STROBE = 5'b01000,
		E_RELEASE = 5'b10000
	} eng_state_e;

	typedef struct packed {
		eng_state_e st;
		logic [2:0] cnt;
		logic [1:0] kind;
		logic [7:0] data;
		logic done;
		logic store_fall;
		logic [7:0] rdata;
		logic ale;
		logic ce_n;
		logic fetch_n;
		logic rd_n;
		logic wr_n;
		logic [4:0] a_hi;
		logic [7:0] bus_o;
		logic bus_oe;
	} eng_s;

	eng_s eng_reg;
	eng_s eng_next;

	always_comb begin
		eng_next = eng_reg;
		eng_next.done = 1'b0;
		eng_next.store_fall = 1'b0;
		case (eng_reg.st)
			E_IDLE: begin
				if (start) begin
					// Select drops with the latch strobe rise, well before its fall
					eng_next.ce_n = 1'b0; // see [R23]
					eng_next.ale = 1'b1;
					eng_next.kind = kind;
					eng_next.data = wdata;
					eng_next.a_hi = addr[12:8];
					eng_next.bus_o = addr[7:0];
					eng_next.bus_oe = 1'b1;
					eng_next.cnt = ALE_CYC - 3'h1;
					eng_next.st = E_ADDR;
				end
			end
			E_ADDR: begin
				if (eng_reg.cnt == 3'h0) begin
					eng_next.ale = 1'b0; // see [R1]
					eng_next.cnt = ADDR_HOLD_CYC - 3'h1;
					eng_next.st = E_HOLD;
				end else begin
					eng_next.cnt = eng_reg.cnt - 3'h1;
				end
			end
			E_HOLD: begin
				if (eng_reg.cnt == 3'h0) begin
					eng_next.bus_oe = 1'b0;
					eng_next.st = E_STROBE;
					case (eng_reg.kind)
						CYC_FETCH: begin
							eng_next.fetch_n = 1'b0; // see [R6]
							eng_next.cnt = FETCH_CYC - 3'h1;
						end
						CYC_READ: begin
							eng_next.rd_n = 1'b0; // see [R7]
							eng_next.cnt = READ_CYC - 3'h1;
						end
						default: begin
							eng_next.wr_n = 1'b0; // see [R8]
							eng_next.store_fall = 1'b1;
							eng_next.cnt = STORE_CYC - 3'h1;
						end
					endcase
				end else begin
					eng_next.cnt = eng_reg.cnt - 3'h1;
				end
			end
			E_STROBE: begin
				// Data follows the store strobe fall by one cycle
				if (eng_reg.kind == CYC_STORE && !eng_reg.bus_oe) begin
					eng_next.bus_oe = 1'b1; // see [R3]
					eng_next.bus_o = eng_reg.data;
				end
				if (eng_reg.cnt == 3'h0) begin
					if (eng_reg.kind != CYC_STORE) begin
						eng_next.rdata = bus_i; // see [R2]
					end
					eng_next.fetch_n = 1'b1;
					eng_next.rd_n = 1'b1;
					eng_next.wr_n = 1'b1;
					eng_next.cnt = DATA_HOLD_CYC - 3'h1;
					eng_next.st = E_RELEASE;
				end else begin
					eng_next.cnt = eng_reg.cnt - 3'h1;
				end
			end
			E_RELEASE: begin
				if (eng_reg.cnt == 3'h0) begin
					eng_next.bus_oe = 1'b0;
					eng_next.ce_n = 1'b1; // see [R5]
					eng_next.done = 1'b1;
					eng_next.st = E_IDLE;
				end else begin
					eng_next.cnt = eng_reg.cnt - 3'h1;
				end
			end
			default: begin
				eng_next.st = E_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eng_reg <= '{st: E_IDLE, ce_n: 1'b1, fetch_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
				default: '0};
		end else begin
			eng_reg <= eng_next;
		end
	end

	assign done = eng_reg.done;
	assign store_fall = eng_reg.store_fall;
	assign rdata = eng_reg.rdata;
	assign ale = eng_reg.ale;
	assign ce_n = eng_reg.ce_n;
	assign fetch_strobe_n = eng_reg.fetch_n;
	assign rd_n = eng_reg.rd_n;
	assign wr_n = eng_reg.wr_n;
	assign addr_hi = eng_reg.a_hi;
	assign bus_o = eng_reg.bus_o;
	assign bus_oe = eng_reg.bus_oe;

endmodule

// ===== core/eeprom_host.sv
// Host controller for a multiplexed-bus electrically erasable memory.
// Assumes an AXI4-Lite master on the register side and the memory pins outside.
//
// Notes on behaviour
// [R1] Address bytes are latched by the memory when the latch strobe falls.
// [R2] A data read returns the byte after the read strobe goes low.
// [R3] Write: latch address, lower store strobe, then present data; captured on rise.
// [R4] With the guard on, three command bytes precede each byte or page write.
// [R5] Chip select high means standby and a released data bus.
// [R6] Select low, fetch strobe low, others high: program fetch.
// [R7] Select low, read strobe low, others high: data read.
// [R8] Select low, fetch and read high, store strobe low: write, bus is input.
// [R9] One program cycle takes a page of one to thirty-two bytes.
// [R10] Every store strobe fall restarts the 100 us byte-load timer.
// [R11] Next page byte must start within 100 us of the previous one.
// [R12] All bytes of one page share address bits 5 to 12.
// [R13] During programming, bit 6 inverts on every read.
// [R14] When programming ends, bit 6 stops toggling; normal access returns.
// [R15] Delivered memory has the write guard disabled.
// [R16] First guarded write enables the guard, kept nonvolatile.
// [R17] Guard stays enabled until the deactivation sequence is written.
// [R18] With the guard on, unguarded data writes are ignored.
// [R19] Locked 1K blocks reject all writes until unlocked.
// [R20] Five command bytes open the lock register; one write then sets it.
// [R21] Lock bytes and lock register write follow page write timing.
// [R22] Write gate low during writes; raising it early cancels programming.
// [R23] Chip select goes low before the latch strobe falls.
// [R24] Internal programming finishes within 5 ms.
// [R25] Lock register has one bit per 1K block, top three address bits.
// [R26] Command byte values and addresses are design parameters.
`timescale 1ns/1ps
module eeprom_host
	import eeprom_host_pkg::*;
#(
	parameter int unsigned PROG_CYC = PROG_CYCLE_CYC_DEFAULT,
	parameter logic [SEQ_TOTAL-1:0][12:0] SEQ_ADDR = SEQ_ADDR_DEFAULT,
	parameter logic [SEQ_TOTAL-1:0][7:0] SEQ_DATA = SEQ_DATA_DEFAULT,
	parameter logic [12:0] BLOCK_LOCK_ADDR = BLOCK_LOCK_ADDR_DEFAULT
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic ale,
	output logic ce_n,
	output logic fetch_strobe_n,
	output logic rd_n,
	output logic wr_n,
	output logic write_gate_n,
	output logic [4:0] addr_hi,
	output logic [7:0] muxed_addr_data_bus_o,
	output logic muxed_addr_data_bus_oe,
	input wire logic [7:0] muxed_addr_data_bus_i
);

	localparam int PW = $clog2(PROG_CYC + 1);

	typedef enum logic [5:0] {
		M_IDLE = 6'b000001,
		M_SEQ = 6'b000010,
		M_ONE = 6'b000100,
		M_DRAIN = 6'b001000,
		M_POLL = 6'b010000,
		M_SPARE = 6'b100000
	} host_state_e;

	typedef struct packed {
		host_state_e st;
		logic awready;
		logic wready;
		logic aw_full;
		logic w_full;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [1:0] ctrl;
		logic [12:0] addr;
		logic [7:0] wbyte;
		logic [7:0] rd_byte;
		logic poll_to;
		logic page_err;
		logic refused;
		logic [3:0] seq_idx;
		logic [3:0] seq_last;
		logic with_data;
		logic [12:0] data_addr;
		logic [11:0] win_cnt;
		logic [PW-1:0] prog_cnt;
		logic [7:0] last_page;
		logic page_live;
		logic toggle_prev;
		logic have_prev;
		logic gate_n;
		logic eng_start;
		logic [1:0] eng_kind;
		logic [12:0] eng_addr;
		logic [7:0] eng_data;
	} host_s;

	host_s host_reg;
	host_s host_next;

	logic eng_done;
	logic eng_store_fall;
	logic [7:0] eng_rdata;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	always_comb begin
		logic [31:0] wm;
		logic [31:0] st_word;
		logic page_ok;
		wm = '0;
		st_word = '0;
		page_ok = 1'b1;
		host_next = host_reg;
		host_next.eng_start = 1'b0;

		// Host mirror of the byte-load timer, restarted on each store fall
		if (eng_store_fall) begin
			host_next.win_cnt = BYTE_LOAD_CYC; // see [R10]
		end else if (host_reg.win_cnt != 12'h0) begin
			host_next.win_cnt = host_reg.win_cnt - 12'h1;
		end
		host_next.gate_n = host_reg.ctrl[CTRL_GATE_HOLD_BIT]; // see [R22]

		st_word[ST_BUSY_BIT] = host_reg.st != M_IDLE;
		st_word[ST_WINDOW_BIT] = host_reg.win_cnt != 12'h0;
		st_word[ST_POLL_TO_BIT] = host_reg.poll_to;
		st_word[ST_PAGE_ERR_BIT] = host_reg.page_err;
		st_word[ST_REFUSED_BIT] = host_reg.refused;
		st_word[ST_TOGGLE_BIT] = host_reg.toggle_prev;

		// Write address and data are taken independently
		if (awvalid && host_reg.awready) begin
			host_next.aw_addr = awaddr;
			host_next.aw_full = 1'b1;
			host_next.awready = 1'b0;
		end
		if (wvalid && host_reg.wready) begin
			host_next.w_data = wdata;
			host_next.w_strb = wstrb;
			host_next.w_full = 1'b1;
			host_next.wready = 1'b0;
		end
		if (host_reg.bvalid && bready) begin
			host_next.bvalid = 1'b0;
			host_next.awready = 1'b1;
			host_next.wready = 1'b1;
		end

		// A command write into a busy state machine is refused, not queued
		if (host_reg.aw_full && host_reg.w_full && !host_reg.bvalid) begin
			host_next.aw_full = 1'b0;
			host_next.w_full = 1'b0;
			host_next.bvalid = 1'b1;
			host_next.bresp = RESP_OKAY;
			page_ok = !(host_reg.ctrl[CTRL_PAGE_MODE_BIT] && host_reg.page_live &&
				host_reg.win_cnt != 12'h0 &&
				host_reg.addr[12:PAGE_LSB] != host_reg.last_page); // see [R12]
			case (host_reg.aw_addr)
				CTRL_OFS: begin
					wm = merge(32'(host_reg.ctrl), host_reg.w_data, host_reg.w_strb);
					host_next.ctrl = wm[1:0];
				end
				ADDR_OFS: begin
					wm = merge(32'(host_reg.addr), host_reg.w_data, host_reg.w_strb);
					host_next.addr = wm[12:0];
				end
				WDATA_OFS: begin
					wm = merge(32'(host_reg.wbyte), host_reg.w_data, host_reg.w_strb);
					host_next.wbyte = wm[7:0];
				end
				STATUS_OFS: begin
					if (host_reg.w_strb[0]) begin
						host_next.poll_to = host_reg.poll_to & ~host_reg.w_data[ST_POLL_TO_BIT];
						host_next.page_err = host_reg.page_err &
							~host_reg.w_data[ST_PAGE_ERR_BIT];
						host_next.refused = host_reg.refused & ~host_reg.w_data[ST_REFUSED_BIT];
					end
				end
				CMD_OFS: begin
					if (!host_reg.w_strb[0]) begin
						host_next.bresp = RESP_OKAY;
					end else if (host_reg.st != M_IDLE) begin
						host_next.refused = 1'b1;
					end else begin
						host_next.eng_addr = host_reg.addr;
						host_next.eng_data = host_reg.wbyte;
						host_next.data_addr = host_reg.addr;
						case (host_reg.w_data[2:0])
							OP_FETCH, OP_READ: begin
								host_next.eng_kind = (host_reg.w_data[2:0] == OP_FETCH) ?
									CYC_FETCH : CYC_READ;
								host_next.eng_start = 1'b1;
								host_next.st = M_ONE;
							end
							OP_WRITE, OP_GUARDED_WRITE: begin
								if (!page_ok) begin
									host_next.page_err = 1'b1;
								end else begin
									host_next.last_page = host_reg.addr[12:PAGE_LSB];
									host_next.page_live = 1'b1; // see [R9]
									host_next.eng_kind = CYC_STORE;
									host_next.eng_start = 1'b1;
									if (host_reg.w_data[2:0] == OP_WRITE) begin
										host_next.st = M_ONE;
									end else begin
										// Guard bytes first, then the data byte
										host_next.seq_idx = GUARD_BASE; // see [R4], [R16]
										host_next.seq_last = GUARD_LAST;
										host_next.with_data = 1'b1;
										host_next.eng_addr = SEQ_ADDR[GUARD_BASE]; // see [R26]
										host_next.eng_data = SEQ_DATA[GUARD_BASE];
										host_next.st = M_SEQ;
									end
								end
							end
							OP_UNGUARD, OP_LOCK_WRITE: begin
								host_next.eng_kind = CYC_STORE;
								host_next.eng_start = 1'b1;
								host_next.st = M_SEQ;
								if (host_reg.w_data[2:0] == OP_UNGUARD) begin
									host_next.seq_idx = UNGUARD_BASE; // see [R17]
									host_next.seq_last = UNGUARD_LAST;
									host_next.with_data = 1'b0;
									host_next.eng_addr = SEQ_ADDR[UNGUARD_BASE];
									host_next.eng_data = SEQ_DATA[UNGUARD_BASE];
								end else begin
									host_next.seq_idx = LOCK_BASE; // see [R20]
									host_next.seq_last = LOCK_LAST;
									host_next.with_data = 1'b1;
									host_next.data_addr = BLOCK_LOCK_ADDR; // see [R25]
									host_next.eng_addr = SEQ_ADDR[LOCK_BASE];
									host_next.eng_data = SEQ_DATA[LOCK_BASE];
								end
							end
							OP_POLL: begin
								host_next.have_prev = 1'b0;
								host_next.st = M_DRAIN;
							end
							default: begin
								host_next.refused = 1'b1;
							end
						endcase
					end
				end
				RDATA_OFS: begin
					host_next.bresp = RESP_OKAY;
				end
				default: begin
					host_next.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Register reads answer one cycle after the address is taken
		if (arvalid && host_reg.arready) begin
			host_next.arready = 1'b0;
			host_next.rvalid = 1'b1;
			host_next.rresp = RESP_OKAY;
			case (araddr)
				CTRL_OFS: host_next.rdata = 32'(host_reg.ctrl);
				CMD_OFS: host_next.rdata = 32'h0;
				ADDR_OFS: host_next.rdata = 32'(host_reg.addr);
				WDATA_OFS: host_next.rdata = 32'(host_reg.wbyte);
				STATUS_OFS: host_next.rdata = st_word;
				RDATA_OFS: host_next.rdata = 32'(host_reg.rd_byte);
				default: begin
					host_next.rdata = 32'h0;
					host_next.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (host_reg.rvalid && rready) begin
			host_next.rvalid = 1'b0;
			host_next.arready = 1'b1;
		end

		case (host_reg.st)
			M_IDLE: begin
				host_next.st = host_next.st;
			end
			M_SEQ: begin
				// Back-to-back stores keep every gap far inside the byte-load window
				if (eng_done) begin
					host_next.eng_start = 1'b1; // see [R21], [R11]
					host_next.eng_kind = CYC_STORE;
					if (host_reg.seq_idx != host_reg.seq_last) begin
						host_next.seq_idx = host_reg.seq_idx + 4'h1;
						host_next.eng_addr = SEQ_ADDR[host_next.seq_idx];
						host_next.eng_data = SEQ_DATA[host_next.seq_idx];
					end else if (host_reg.with_data) begin
						host_next.eng_addr = host_reg.data_addr;
						host_next.eng_data = host_reg.wbyte;
						host_next.st = M_ONE;
					end else begin
						host_next.eng_start = 1'b0;
						host_next.st = M_IDLE;
					end
				end
			end
			M_ONE: begin
				if (eng_done) begin
					if (host_reg.eng_kind != CYC_STORE) begin
						host_next.rd_byte = eng_rdata;
					end
					host_next.st = M_IDLE;
				end
			end
			M_DRAIN: begin
				// Polling before the window closes would only see a loading page
				if (host_reg.win_cnt == 12'h0) begin
					host_next.prog_cnt = PW'(PROG_CYC); // see [R24]
					host_next.eng_kind = CYC_READ;
					host_next.eng_start = 1'b1;
					host_next.st = M_POLL;
				end
			end
			M_POLL: begin
				if (host_reg.prog_cnt != '0) begin
					host_next.prog_cnt = host_reg.prog_cnt - PW'(1);
				end
				if (eng_done) begin
					host_next.rd_byte = eng_rdata;
					host_next.toggle_prev = eng_rdata[TOGGLE_FLAG_BIT];
					host_next.have_prev = 1'b1;
					if (host_reg.have_prev &&
						eng_rdata[TOGGLE_FLAG_BIT] == host_reg.toggle_prev) begin
						host_next.page_live = 1'b0; // see [R14]
						host_next.st = M_IDLE;
					end else if (host_reg.prog_cnt == '0) begin
						host_next.poll_to = 1'b1;
						host_next.st = M_IDLE;
					end else begin
						host_next.eng_start = 1'b1; // see [R13]
					end
				end
			end
			default: begin
				host_next.st = M_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			host_reg <= '{st: M_IDLE, awready: 1'b1, wready: 1'b1, arready: 1'b1,
				ctrl: CTRL_RESET, default: '0};
		end else begin
			host_reg <= host_next;
		end
	end

	bus_cycle_engine i_bus_cycle_engine (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(host_reg.eng_start),
		.kind(host_reg.eng_kind),
		.addr(host_reg.eng_addr),
		.wdata(host_reg.eng_data),
		.done(eng_done),
		.store_fall(eng_store_fall),
		.rdata(eng_rdata),
		.ale(ale),
		.ce_n(ce_n),
		.fetch_strobe_n(fetch_strobe_n),
		.rd_n(rd_n),
		.wr_n(wr_n),
		.addr_hi(addr_hi),
		.bus_o(muxed_addr_data_bus_o),
		.bus_oe(muxed_addr_data_bus_oe),
		.bus_i(muxed_addr_data_bus_i)
	);

	assign awready = host_reg.awready;
	assign wready = host_reg.wready;
	assign bvalid = host_reg.bvalid;
	assign bresp = host_reg.bresp;
	assign arready = host_reg.arready;
	assign rvalid = host_reg.rvalid;
	assign rresp = host_reg.rresp;
	assign rdata = host_reg.rdata;
	assign write_gate_n = host_reg.gate_n;

endmodule

// ===== tb/eeprom_host_assertions.sv
// Pin and timing checks on the memory host.
// Assumes binding to eeprom_host, one clock domain.
`timescale 1ns/1ps
module eeprom_host_assertions(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ale,
	input wire logic ce_n,
	input wire logic fetch_strobe_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] muxed_addr_data_bus_o,
	input wire logic muxed_addr_data_bus_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence ale_pulse;
		ale [*2] ##1 !ale;
	endsequence
	sequence store_pulse;
		!wr_n [*3] ##1 wr_n;
	endsequence
	standby_quiet_a: assert property (
		ce_n |-> fetch_strobe_n && rd_n && wr_n && !muxed_addr_data_bus_oe)
		else $error("active in standby");
	one_mode_a: assert property (
		$onehot0({!fetch_strobe_n, !rd_n, !wr_n})) else $error("two strobes low");
	read_bus_free_a: assert property (
		!(rd_n && fetch_strobe_n) |-> !muxed_addr_data_bus_oe) else $error("bus fight");
	store_data_a: assert property (
		$rose(wr_n) |-> muxed_addr_data_bus_oe && $stable(muxed_addr_data_bus_o))
		else $error("store data lost");
	ale_fall_a: assert property (
		$fell(ale) |-> !ce_n && muxed_addr_data_bus_oe) else $error("bad latch");
	ale_width_a: assert property (
		$rose(ale) |-> ale_pulse) else $error("latch width");
	store_width_a: assert property (
		$fell(wr_n) |-> store_pulse) else $error("store width");
	select_start_a: assert property (
		$fell(ce_n) |-> ale && muxed_addr_data_bus_oe) else $error("select early");
endmodule
bind eeprom_host eeprom_host_assertions i_chk(.aclk, .aresetn, .ale, .ce_n, .fetch_strobe_n,
	.rd_n, .wr_n, .muxed_addr_data_bus_o, .muxed_addr_data_bus_oe);

// ===== tb/mem_model.sv
// Behavioural memory on the multiplexed bus.
// Assumes host pins change on aclk; no guard or lock logic.
`timescale 1ns/1ps
module mem_model(
	input wire logic aclk,
	input wire logic ale,
	input wire logic ce_n,
	input wire logic fetch_strobe_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [4:0] addr_hi,
	input wire logic [7:0] bus_o,
	input wire logic bus_oe,
	output logic [7:0] bus_i
);
	logic [7:0] mem [8192];
	logic [12:0] a;
	logic [7:0] q;
	logic [7:0] last = 8'h00;
	logic t = 1'b0;
	int cnt = 0;
	int n_st = 0;
	int n_tog = 0;
	wire drv = !ce_n && wr_n && (!rd_n ^ !fetch_strobe_n);
	always @(negedge ale) if (!ce_n) a = {addr_hi, bus_o};
	always @(negedge rd_n or negedge fetch_strobe_n) begin
		q = mem[a];
		if (cnt != 0) begin
			t = !t;
			n_tog++;
			q[6] = t;
		end
	end
	always @(posedge wr_n) if (!ce_n && bus_oe) begin
		mem[a] = bus_o;
		n_st++;
	end
	// Window plus a short program time
	always @(posedge aclk) cnt <= !wr_n ? 2600 : (cnt != 0 ? cnt - 1 : 0);
	// Released bus flips each cycle so stale data never looks valid
	always @(posedge aclk) last <= bus_i;
	assign bus_i = drv ? q : (bus_oe ? bus_o : ~last);
endmodule

// ===== tb/eeprom_host_tb.sv
// Bench for the memory host: AXI4-Lite tasks, memory model on the pins.
// Assumes package offsets and a shortened program time.
`timescale 1ns/1ps
module eeprom_host_tb;
	import eeprom_host_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, bus_o, bus_i;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [1:0] bresp, rresp, r;
	logic awready, wready, bvalid, arready, rvalid, ale, ce_n, fetch_strobe_n, rd_n, wr_n;
	logic write_gate_n, bus_oe;
	logic [4:0] addr_hi;
	int errors = 0, comparisons = 0, cyc = 0, n;
	eeprom_host #(.PROG_CYC(200)) i_eeprom_host(.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .ale, .ce_n, .fetch_strobe_n, .rd_n, .wr_n,
		.write_gate_n, .addr_hi, .muxed_addr_data_bus_o(bus_o),
		.muxed_addr_data_bus_oe(bus_oe), .muxed_addr_data_bus_i(bus_i));
	mem_model i_mem_model(.aclk, .ale, .ce_n, .fetch_strobe_n, .rd_n, .wr_n, .addr_hi, .bus_o,
		.bus_oe, .bus_i);
	initial forever #20 aclk = !aclk;
	always @(posedge aclk) if (++cyc == 60000) begin
		errors++;
		close_out;
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) bready <= 1'b0;
			r = bresp;
		end while (bvalid !== 1'b1);
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) rready <= 1'b0;
			v = rdata;
			r = rresp;
		end while (rvalid !== 1'b1);
	endtask
	task automatic go(input logic [2:0] op);
		wr(CMD_OFS, {29'h0, op});
		do rd(STATUS_OFS); while (v[ST_BUSY_BIT] !== 1'b0);
	endtask
	task automatic t_reset;
		rd(CTRL_OFS);
		chk("ctrl", v, 32'h0);
		rd(STATUS_OFS);
		chk("status", v, 32'h0);
		rd(8'h20);
		chk("unmapped", r, RESP_SLVERR);
		wr(8'h20, 32'h0);
		chk("wr_unmapped", r, RESP_SLVERR);
		wr(CMD_OFS, 32'h7);
		rd(STATUS_OFS);
		chk("refused", v[ST_REFUSED_BIT], 1'b1);
		wr(STATUS_OFS, 32'h10);
		chk("gate", write_gate_n, 1'b0);
	endtask
	task automatic t_rw;
		wr(ADDR_OFS, 32'h0123);
		wr(WDATA_OFS, 32'h5a);
		go(OP_WRITE);
		chk("store", i_mem_model.mem[13'h0123], 8'h5a);
		go(OP_POLL);
		chk("toggles", i_mem_model.n_tog != 0, 1'b1);
		rd(STATUS_OFS);
		chk("poll_to", v[ST_POLL_TO_BIT], 1'b0);
		go(OP_READ);
		rd(RDATA_OFS);
		chk("rdata", v[7:0], 8'h5a);
		i_mem_model.mem[13'h1f00] = 8'hc3;
		wr(ADDR_OFS, 32'h1f00);
		go(OP_FETCH);
		rd(RDATA_OFS);
		chk("fetch", v[7:0], 8'hc3);
	endtask
	task automatic t_page;
		n = i_mem_model.n_st;
		wr(ADDR_OFS, 32'h0040);
		wr(WDATA_OFS, 32'h3c);
		go(OP_GUARDED_WRITE);
		chk("seq_n", i_mem_model.n_st - n, 4);
		chk("seq", i_mem_model.mem[SEQ_ADDR_DEFAULT[2]], SEQ_DATA_DEFAULT[2]);
		chk("guarded", i_mem_model.mem[13'h0040], 8'h3c);
		wr(CTRL_OFS, 32'h2);
		wr(ADDR_OFS, 32'h0060);
		go(OP_WRITE);
		rd(STATUS_OFS);
		chk("page_err", v[ST_PAGE_ERR_BIT], 1'b1);
		wr(ADDR_OFS, 32'h0041);
		wr(WDATA_OFS, 32'h77);
		go(OP_WRITE);
		chk("page", i_mem_model.mem[13'h0041], 8'h77);
		go(OP_POLL);
		wr(STATUS_OFS, 32'h8);
		rd(STATUS_OFS);
		chk("w1c", v[ST_PAGE_ERR_BIT], 1'b0);
	endtask
	task automatic t_ops;
		wr(CTRL_OFS, 32'h1);
		repeat (2) @(posedge aclk);
		chk("hold", write_gate_n, 1'b1);
		wr(CTRL_OFS, 32'h0);
		for (int op = 4; op < 6; op++) begin
			n = i_mem_model.n_st;
			go(op[2:0]);
			chk("seq_len", i_mem_model.n_st - n, 6);
		end
		chk("lock", i_mem_model.mem[BLOCK_LOCK_ADDR_DEFAULT], 8'h77);
	endtask
	task close_out;
		if (errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_rw;
		t_page;
		t_ops;
		close_out;
	end
endmodule
